// *** i2c_ctl_pkg.sv ***
// Package with register map, field layout and shared types of the two-wire status block.
package i2c_ctl_pkg;

  // Register index on the plain register port.
  localparam logic [3:0] OFS_OWN_ADDR_0   = 4'h0;
  localparam logic [3:0] OFS_OWN_ADDR_1   = 4'h1;
  localparam logic [3:0] OFS_OWN_ADDR_2   = 4'h2;
  localparam logic [3:0] OFS_CONTROL_1    = 4'h3;
  localparam logic [3:0] OFS_CONTROL_3    = 4'h4;
  localparam logic [3:0] OFS_TIMEOUT_CTRL = 4'h5;
  localparam logic [3:0] OFS_STATUS_CMD   = 4'h6;
  localparam logic [3:0] OFS_DATA_SHIFT   = 4'h7;

  // Field positions in the control register 1.
  localparam int BIT_IFACE_ENABLE = 0;
  localparam int BIT_IFACE_RESET  = 1;
  localparam int BIT_FREE_FORMAT  = 2;

  // Field positions in control register 3.
  localparam int BIT_STOP_IRQ_EN  = 0;
  localparam int BIT_DIV_LOW_LSB  = 6;

  // Field positions in the timeout, clock and address control register.
  localparam int BIT_TO_ENABLE    = 0;
  localparam int BIT_TO_FLAG      = 1;
  localparam int BIT_TO_PERIOD    = 2;
  localparam int BIT_DIV_EXT_LSB  = 3;
  localparam int BIT_ADDR_BANK    = 6;
  localparam int BIT_STOP_REQ     = 7;

  // Values after reset.
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Status write patterns.
  localparam logic [3:0] PAT_MODE_ONLY  = 4'hf;
  localparam logic [7:0] PAT_START      = 8'he0;
  localparam logic [7:0] PAT_STOP       = 8'hc0;

  // Divide ratios in half steps (ratio times two).
  localparam logic [4:0] DIV2X_2   = 5'd4;
  localparam logic [4:0] DIV2X_4   = 5'd8;
  localparam logic [4:0] DIV2X_8   = 5'd16;
  localparam logic [4:0] DIV2X_2P5 = 5'd5;
  localparam logic [4:0] DIV2X_3   = 5'd6;
  localparam logic [4:0] DIV2X_5   = 5'd10;
  localparam logic [4:0] DIV2X_6   = 5'd12;
  localparam logic [4:0] DIV_STEP  = 5'd2;

  // Last count before the timeout fires: 65535 and 16383, so it fires after 65536 and 16384 bus clock ticks.
  localparam logic [15:0] TO_LONG_LAST  = 16'hffff;
  localparam logic [13:0] TO_SHORT_LAST = 14'h3fff;

  // Events from the bit engine, all on clk_sys_i.
  typedef struct packed {
    logic       start_det;
    logic       stop_det;
    logic       addr_rcvd;
    logic [6:0] addr_val;
    logic       addr_rw;
    logic       bit_rcvd;
    logic       bit_val;
    logic       byte_done;
    logic       addr_phase;
    logic       data_phase;
    logic       cond_phase;
    logic       ack_clock;
    logic       sda_out_high;
    logic       overlap_protect;
    logic       pending_n;
  } bus_event_t;

  // Commands and state towards the bit engine.
  typedef struct packed {
    logic       start_req;
    logic       stop_req;
    logic       master;
    logic       transmit;
    logic       bus_tick;
    logic       timeout_irq;
    logic       stop_irq;
    logic       addr_match;
    logic [7:0] tx_data;
  } bus_ctrl_t;

endpackage

// *** bus_clock_divider.sv ***
// Fractional divider that makes the internal bus clock enable pulse.
module bus_clock_divider (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       run_i,
  input  wire logic [4:0] div2x_i,
  output logic            tick_o
);
  import i2c_ctl_pkg::*;

  logic [4:0] acc_q;
  logic [4:0] acc_d;
  logic       tick_d;
  logic [5:0] sum;

  // Adding two per cycle against twice the ratio gives half-step ratios such as 2.5.
  assign sum    = {1'b0, acc_q} + {1'b0, DIV_STEP};
  assign tick_d = run_i && (sum >= {1'b0, div2x_i});
  assign acc_d  = !run_i ? 5'h00 : (tick_d ? sum[4:0] - div2x_i : sum[4:0]);

  // The accumulator stops and clears while the interface is off.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q  <= 5'h00;
      tick_o <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      tick_o <= tick_d;
    end
  end

endmodule // bus_clock_divider

// *** i2c_clock_timeout_status.sv ***
// Clock select, bus timeout, address bank and status/command logic of the two-wire controller.

// Summary of operation
// R01: Bus clock is source divided by 2,4,8,2.5,3,5 or 6 from the five-bit code.
// R02: Software uses only the listed divider codes; others are unsupported.
// R03: Software changes divider fields only while the interface is disabled.
// R04: Busy and clock line high past the period sets timeout flag and interrupt together.
// R05: Timeout flag works only when enabled; disable or interface reset clears it.
// R06: Counter counts bus clock ticks: 65536 long, 16384 short.
// R07: Software changes the period select only while timeout detection is off.
// R08: Bank bit picks own address 0 alone or all three own addresses.
// R09: Stop with its interrupt enabled sets stop request; only a written 0 clears.
// R10: Six low status bits are read-only; writes still request start or stop.
// R11: Low nibble 1111b updates master and transmit only, no condition.
// R12: Master, transmit, busy, zeros gives start standby; busy zero gives stop standby.
// R13: Mode bits pick slave/master receive/transmit; monitor bits stay unchanged.
// R14: Last bit holds the final received bit; data register write clears it.
// R15: General call sets on all-zero slave address; start, stop, disable, reset clear.
// R16: Address match sets on general call or own match; data write, disable, reset clear.
// R17: Data line pulled low during master address or transmit data outside ack sets lost flag.
// R18: Lost flag also sets on low data line during conditions or overlap protection.
// R19: Internal bus clock stops while the interface is disabled.
// R20: Timeout counter restarts on clock line low or free bus.
module i2c_clock_timeout_status (
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_n_i,
  input  wire logic [3:0]              reg_addr_i,
  input  wire logic [7:0]              reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic      [7:0]              reg_rdata_o,
  input  wire logic                    clock_line_pin_i,
  input  wire logic                    data_line_pin_i,
  input  wire i2c_ctl_pkg::bus_event_t evt_i,
  output i2c_ctl_pkg::bus_ctrl_t       ctrl_o
);
  import i2c_ctl_pkg::*;

  // Software registers.
  logic [7:0]  own_addr_q [3];
  logic [2:0]  control_1_q;
  logic        stop_irq_en_q;
  logic [1:0]  div_low_q;
  logic [2:0]  div_ext_q;
  logic        to_enable_q;
  logic        to_period_q;
  logic        addr_bank_q;
  logic [7:0]  data_shift_q;
  // Hardware flags.
  logic        stop_req_q;
  logic        to_flag_q;
  logic        master_q;
  logic        transmit_q;
  logic        busy_q;
  logic        lost_q;
  logic        match_q;
  logic        gcall_q;
  logic        last_bit_q;
  logic [15:0] to_cnt_q;
  logic [15:0] to_cnt_d;
  logic        start_req_q;
  logic        stop_cmd_q;
  logic        to_irq_q;
  logic        stop_irq_q;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  // Pin synchronisers: stage one feeds stage two only.
  logic [1:0]  pin_meta_q;
  logic [1:0]  pin_sync_q;

  // Decoded strobes.
  logic wr_ctl1, wr_ctl3, wr_to, wr_stat, wr_data;
  logic iface_on, iface_clr, tick, scl_high, sda_low;
  logic [4:0] div2x;
  logic gc_hit, own_hit, addr_ok, slave_addr, lost_ev, to_expire, to_set, stop_set;
  logic mode_only, pat_start, pat_stop;

  assign wr_ctl1   = reg_wr_i && (reg_addr_i == OFS_CONTROL_1);
  assign wr_ctl3   = reg_wr_i && (reg_addr_i == OFS_CONTROL_3);
  assign wr_to     = reg_wr_i && (reg_addr_i == OFS_TIMEOUT_CTRL);
  assign wr_stat   = reg_wr_i && (reg_addr_i == OFS_STATUS_CMD);
  assign wr_data   = reg_wr_i && (reg_addr_i == OFS_DATA_SHIFT);

  // Interface clear covers both disable and interface reset.
  assign iface_on  = control_1_q[BIT_IFACE_ENABLE];
  assign iface_clr = !iface_on || control_1_q[BIT_IFACE_RESET];
  assign scl_high  = pin_sync_q[0];
  assign sda_low   = !pin_sync_q[1];

  // Divider code select; unsupported codes fall back to divide by two.
  // A code changed while enabled upsets the tick spacing.
  always_comb begin
    unique case (div_ext_q)                                      // [R01]
      3'b001:  div2x = DIV2X_2P5;
      3'b010:  div2x = DIV2X_3;
      3'b011:  div2x = DIV2X_5;
      3'b100:  div2x = DIV2X_6;
      3'b000: begin
        unique case (div_low_q)
          2'b01:   div2x = DIV2X_4;
          2'b10:   div2x = DIV2X_8;
          default: div2x = DIV2X_2;                              // [R02]
        endcase
      end
      default: div2x = DIV2X_2;                                  // [R02]
    endcase
  end

  // The divider only runs while enabled, so the bus clock stops with it.
  bus_clock_divider u_div (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .run_i     (iface_on),                                       // [R19]
    .div2x_i   (div2x),
    .tick_o    (tick)
  );

  // Timeout: count continuous clock-line high time while busy.
  assign to_expire = tick && (to_period_q ? (to_cnt_q[13:0] == TO_SHORT_LAST)
                                          : (to_cnt_q == TO_LONG_LAST));  // [R06]
  assign to_set    = to_enable_q && busy_q && scl_high && to_expire;     // [R04] [R05]
  assign to_cnt_d  = (!busy_q || !scl_high || !to_enable_q) ? 16'h0000   // [R20]
                   : (tick ? to_cnt_q + 16'h0001 : to_cnt_q);            // [R06]

  // Slave address compare, general call included.
  // Bit zero of an own-address register is no address bit.
  assign slave_addr = evt_i.addr_rcvd && !master_q && !control_1_q[BIT_FREE_FORMAT];
  assign gc_hit     = evt_i.addr_val == 7'h00;
  assign own_hit    = (evt_i.addr_val == own_addr_q[0][7:1]) ||
                      (addr_bank_q && ((evt_i.addr_val == own_addr_q[1][7:1]) ||
                                       (evt_i.addr_val == own_addr_q[2][7:1])));  // [R08]
  assign addr_ok    = slave_addr && !transmit_q && (gc_hit || own_hit);          // [R16]

  // Another driver pulls data low while this end releases it.
  // A line driven low here proves nothing.
  assign lost_ev = evt_i.overlap_protect ||                                      // [R18]
                   (master_q && sda_low && evt_i.sda_out_high &&
                    (evt_i.cond_phase ||                                         // [R18]
                     ((evt_i.addr_phase || (evt_i.data_phase && transmit_q)) &&
                      !evt_i.ack_clock)));                                       // [R17]

  assign stop_set  = evt_i.stop_det && stop_irq_en_q;                            // [R09]

  // Status write decode; only mode-only, start and stop patterns act.
  assign mode_only = reg_wdata_i[3:0] == PAT_MODE_ONLY;                          // [R11]
  assign pat_start = reg_wdata_i == PAT_START;                                   // [R12]
  assign pat_stop  = reg_wdata_i == PAT_STOP;                                    // [R12]

  // Two-flop synchronisers on the clock and data lines.
  // They reset high, the idle level, so no false low follows.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_q <= 2'b11;
      pin_sync_q <= 2'b11;
    end else begin
      pin_meta_q <= {data_line_pin_i, clock_line_pin_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  // Software-owned control fields; the divider and period fields rely on software care.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 3; i++) own_addr_q[i] <= RST_BYTE;
      control_1_q   <= 3'b000;
      stop_irq_en_q <= 1'b0;
      div_low_q     <= 2'b00;
      div_ext_q     <= 3'b000;
      to_enable_q   <= 1'b0;
      to_period_q   <= 1'b0;
      addr_bank_q   <= 1'b0;
      data_shift_q  <= RST_BYTE;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (reg_wr_i && reg_addr_i == 4'(i)) own_addr_q[i] <= reg_wdata_i;
      end
      if (wr_ctl1) control_1_q <= reg_wdata_i[2:0];
      if (wr_ctl3) begin
        stop_irq_en_q <= reg_wdata_i[BIT_STOP_IRQ_EN];
        div_low_q     <= reg_wdata_i[BIT_DIV_LOW_LSB +: 2];           // [R03]
      end
      if (wr_to) begin
        to_enable_q <= reg_wdata_i[BIT_TO_ENABLE];
        to_period_q <= reg_wdata_i[BIT_TO_PERIOD];                     // [R07]
        div_ext_q   <= reg_wdata_i[BIT_DIV_EXT_LSB +: 3];              // [R03]
        addr_bank_q <= reg_wdata_i[BIT_ADDR_BANK];
      end
      if (wr_data) data_shift_q <= reg_wdata_i;
    end
  end

  // Timeout counter and flag; the set wins over a clear in the same cycle.
  // No second interrupt while the flag stays set.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      to_cnt_q  <= 16'h0000;
      to_flag_q <= 1'b0;
      to_irq_q  <= 1'b0;
    end else begin
      to_cnt_q <= to_cnt_d;
      to_irq_q <= to_set && !to_flag_q;                               // [R04]
      if (to_set) to_flag_q <= 1'b1;                                   // [R04]
      else if (iface_clr) to_flag_q <= 1'b0;                           // [R05]
    end
  end

  // Stop request flag: hardware sets it, only a written zero clears it.
  // Writing a one is harmless.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_req_q <= 1'b0;
      stop_irq_q <= 1'b0;
    end else begin
      stop_irq_q <= stop_set;
      if (stop_set) stop_req_q <= 1'b1;                                // [R09]
      else if (wr_to && !reg_wdata_i[BIT_STOP_REQ]) stop_req_q <= 1'b0;  // [R09]
    end
  end

  // Bus busy, general call, address match, lost and last bit monitors.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q     <= 1'b0;
      gcall_q    <= 1'b0;
      match_q    <= 1'b0;
      lost_q     <= 1'b0;
      last_bit_q <= 1'b0;
    end else begin
      if (evt_i.start_det) busy_q <= 1'b1;
      else if (evt_i.stop_det || iface_clr) busy_q <= 1'b0;
      if (slave_addr && gc_hit) gcall_q <= 1'b1;                       // [R15]
      else if (evt_i.start_det || evt_i.stop_det || iface_clr) gcall_q <= 1'b0;  // [R15]
      if (addr_ok) match_q <= 1'b1;                                    // [R16]
      else if (wr_data || iface_clr) match_q <= 1'b0;                  // [R16]
      if (lost_ev) lost_q <= 1'b1;                                     // [R17]
      else if (wr_data || iface_clr) lost_q <= 1'b0;                   // [R17]
      if (evt_i.bit_rcvd) last_bit_q <= evt_i.bit_val;                 // [R14]
      else if (wr_data) last_bit_q <= 1'b0;                            // [R14]
    end
  end

  // Mode bits and start/stop commands from status writes.
  // A stop write in slave mode makes no stop request but still loads the mode bits.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      master_q    <= 1'b0;
      transmit_q  <= 1'b0;
      start_req_q <= 1'b0;
      stop_cmd_q  <= 1'b0;
    end else begin
      start_req_q <= wr_stat && !mode_only && pat_start && !iface_clr;   // [R10] [R12]
      stop_cmd_q  <= wr_stat && !mode_only && pat_stop && master_q && !iface_clr;  // [R12]
      if (iface_clr || evt_i.stop_det || evt_i.overlap_protect) begin
        master_q   <= 1'b0;
        transmit_q <= 1'b0;
      end else if (wr_stat && (mode_only || pat_start || pat_stop)) begin
        master_q   <= reg_wdata_i[7];                                  // [R11] [R13]
        transmit_q <= reg_wdata_i[6];                                  // [R13]
      end else begin
        if (lost_ev) transmit_q <= 1'b0;
        else if (addr_ok && evt_i.addr_rw) transmit_q <= 1'b1;
        else if (evt_i.start_det && !master_q) transmit_q <= 1'b0;
        if (lost_q && evt_i.byte_done) master_q <= 1'b0;
      end
    end
  end

  // Read mux; the six low status bits come only from hardware state.
  // Unmapped indices read zero.
  always_comb begin
    rdata_d = 8'h00;
    unique case (reg_addr_i)
      OFS_OWN_ADDR_0:   rdata_d = own_addr_q[0];
      OFS_OWN_ADDR_1:   rdata_d = own_addr_q[1];
      OFS_OWN_ADDR_2:   rdata_d = own_addr_q[2];
      OFS_CONTROL_1:    rdata_d = {5'h00, control_1_q};
      OFS_CONTROL_3:    rdata_d = {div_low_q, 5'h00, stop_irq_en_q};
      OFS_TIMEOUT_CTRL: rdata_d = {stop_req_q, addr_bank_q, div_ext_q,
                                   to_period_q, to_flag_q, to_enable_q};
      OFS_STATUS_CMD:   rdata_d = {master_q, transmit_q, busy_q, evt_i.pending_n,
                                   lost_q, match_q, gcall_q, last_bit_q};   // [R10]
      OFS_DATA_SHIFT:   rdata_d = data_shift_q;
      default:          rdata_d = 8'h00;
    endcase
  end

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) rdata_q <= 8'h00;
    else rdata_q <= reg_rd_i ? rdata_d : 8'h00;
  end

  // Outputs towards the register port and the bit engine.
  assign reg_rdata_o          = rdata_q;
  assign ctrl_o.start_req     = start_req_q;
  assign ctrl_o.stop_req      = stop_cmd_q;
  assign ctrl_o.master        = master_q;
  assign ctrl_o.transmit      = transmit_q;
  assign ctrl_o.bus_tick      = tick;
  assign ctrl_o.timeout_irq   = to_irq_q;
  assign ctrl_o.stop_irq      = stop_irq_q;
  assign ctrl_o.addr_match    = match_q;
  assign ctrl_o.tx_data       = data_shift_q;

endmodule // i2c_clock_timeout_status

// *** i2c_clock_timeout_status_properties.sv ***
// Port-level assertions for the two-wire clock, timeout and status block.
module i2c_status_checker (
  input wire logic                    clk_sys_i,
  input wire logic                    rst_n_i,
  input wire logic [3:0]              reg_addr_i,
  input wire logic [7:0]              reg_wdata_i,
  input wire logic                    reg_wr_i,
  input wire logic                    reg_rd_i,
  input wire logic [7:0]              reg_rdata_o,
  input wire logic                    clock_line_pin_i,
  input wire logic                    data_line_pin_i,
  input wire i2c_ctl_pkg::bus_event_t evt_i,
  input wire i2c_ctl_pkg::bus_ctrl_t  ctrl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import i2c_ctl_pkg::*;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  // Raw clock-line high time; it saturates, since only a lower bound matters.
  logic [15:0] high_q;
  logic [15:0] high_d;
  assign high_d = !clock_line_pin_i ? 16'h0000 : high_q + {15'h0000, ~&high_q};
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      high_q <= 16'h0000;
    end else begin
      high_q <= high_d;
    end
  end

  // Status writes, mode-only writes and data register writes that no set competes with.
  sequence s_status_wr;
    reg_wr_i && reg_addr_i == OFS_STATUS_CMD;
  endsequence
  sequence s_mode_wr;
    s_status_wr ##0 reg_wdata_i[3:0] == PAT_MODE_ONLY;
  endsequence
  sequence s_data_wr;
    reg_wr_i && reg_addr_i == OFS_DATA_SHIFT && !evt_i.addr_rcvd;
  endsequence

  AST_START_CAUSE: assert property (
    ctrl_o.start_req |-> $past(reg_wr_i && reg_addr_i == OFS_STATUS_CMD && reg_wdata_i == PAT_START))
    else $error("start request without a start write");
  AST_STOP_CAUSE: assert property (
    ctrl_o.stop_req |-> $past(reg_wr_i && reg_addr_i == OFS_STATUS_CMD && reg_wdata_i == PAT_STOP))
    else $error("stop request without a stop write");
  AST_MODE_NO_COND: assert property (
    s_mode_wr |=> !ctrl_o.start_req && !ctrl_o.stop_req)
    else $error("mode-only write made a condition");
  AST_STATUS_MODE_READ: assert property (
    reg_rd_i && reg_addr_i == OFS_STATUS_CMD |=>
      reg_rdata_o[7:6] == $past({ctrl_o.master, ctrl_o.transmit}))
    else $error("status read disagrees with mode outputs");
  AST_STOP_IRQ_CAUSE: assert property (
    ctrl_o.stop_irq |-> $past(evt_i.stop_det))
    else $error("stop interrupt without a stop");
  AST_TIMEOUT_HIGH: assert property (
    ctrl_o.timeout_irq |-> high_q >= 16'd32760)
    else $error("timeout before the clock line was high long enough");
  AST_TICK_SPACING: assert property (
    ctrl_o.bus_tick |=> !ctrl_o.bus_tick)
    else $error("bus clock faster than half the source");
  AST_MATCH_CLEAR: assert property (
    s_data_wr |=> !ctrl_o.addr_match)
    else $error("address match survived a data write");
endmodule // i2c_status_checker

bind i2c_clock_timeout_status i2c_status_checker u_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .clock_line_pin_i(clock_line_pin_i),
  .data_line_pin_i(data_line_pin_i), .evt_i(evt_i), .ctrl_o(ctrl_o));

// *** i2c_bus_peer.sv ***
// Behavioural far side of the two-wire bus: line levels and bit-engine events.
module i2c_bus_peer (
  input  wire logic                clk_sys_i,
  output logic                     scl_o,
  output logic                     sda_o,
  output i2c_ctl_pkg::bus_event_t  evt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import i2c_ctl_pkg::*;

  // Both lines have pull-ups, so a released line idles high.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    evt_o = '0;
  end

  // Show an event pattern for n cycles, then fall quiet.
  task automatic hold(input bus_event_t e, input int n);
    @(posedge clk_sys_i);
    evt_o <= e;
    repeat (n) @(posedge clk_sys_i);
    evt_o <= '0;
  endtask

  // Pull one line low for n cycles, as another master would.
  task automatic pull(input logic clock_line, input int n);
    @(posedge clk_sys_i);
    if (clock_line) begin
      scl_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
    repeat (n) @(posedge clk_sys_i);
    scl_o <= 1'b1;
    sda_o <= 1'b1;
  endtask
endmodule // i2c_bus_peer

// *** tb_i2c_clock_timeout_status.sv ***
// Self-checking bench for the two-wire clock, timeout and status block.
module tb_i2c_clock_timeout_status;
  timeunit 1ns;
  timeprecision 1ps;
  import i2c_ctl_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic       scl;
  logic       sda;
  bus_event_t evt;
  bus_ctrl_t  ctrl_o;
  logic [7:0] exp_q[$];
  logic       rd_seen = 1'b0;
  int         n_errors = 0;
  int         num_checks = 0;
  int         n;
  logic [6:0] a0;
  logic [4:0] codes[7] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h00};
  logic [4:0] divs[7] = '{DIV2X_4, DIV2X_8, DIV2X_2P5, DIV2X_3, DIV2X_5, DIV2X_6, DIV2X_2};

  always #4 clk_sys_i = ~clk_sys_i;

  i2c_clock_timeout_status DUT (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .clock_line_pin_i(scl), .data_line_pin_i(sda),
    .evt_i(evt), .ctrl_o(ctrl_o));
  i2c_bus_peer peer (.clk_sys_i(clk_sys_i), .scl_o(scl), .sda_o(sda), .evt_o(evt));

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask

  // Register write: one strobe cycle, then the edge that takes it has landed.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  // Register read: the expectation is queued, the monitor below compares it.
  task automatic rd(input logic [3:0] a, input logic [7:0] want);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    exp_q.push_back(want);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
  endtask

  // Read data stand for one cycle only, so they are taken at its falling edge.
  always @(posedge clk_sys_i) rd_seen <= reg_rd_i;
  always @(negedge clk_sys_i) begin
    if (rd_seen && exp_q.size() > 0) begin
      check(reg_rdata_o, exp_q.pop_front());
    end
  end

  task automatic count_ticks(input int cyc, output int cnt);
    cnt = 0;
    repeat (cyc) begin
      @(posedge clk_sys_i);
      #1;
      if (ctrl_o.bus_tick === 1'b1) cnt++;
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    a0 = 7'($urandom(32'h406f));
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 9; i++) rd(4'(i), RST_BYTE);
    wr(4'h9, 8'($urandom));
    rd(4'h9, 8'h00);
    $display("Test reset values done");
    // Divider codes; fields change only with the interface off, don't-care bits random.
    foreach (codes[i]) begin
      if (i > 1 && i < 6) codes[i] = codes[i] | 5'($urandom_range(0, 3));
      wr(OFS_CONTROL_1, 8'h00);
      count_ticks(20, n);
      check(8'(n), 8'h00);
      wr(OFS_CONTROL_3, {codes[i][1:0], 6'h00});
      wr(OFS_TIMEOUT_CTRL, {2'b00, codes[i][4:2], 3'b000});
      rd(OFS_CONTROL_3, {codes[i][1:0], 6'h00});
      wr(OFS_CONTROL_1, 8'h01);
      count_ticks(480, n);
      check({7'h00, (n >= 960 / divs[i] - 1) && (n <= 960 / divs[i] + 1)}, 8'h01);
    end
    $display("Test clock divider done");
    wr(OFS_STATUS_CMD, PAT_START);
    check({6'h00, ctrl_o.start_req, ctrl_o.master}, 8'h03);
    peer.hold(bus_event_t'{start_det: 1'b1, default: '0}, 1);
    rd(OFS_STATUS_CMD, 8'he0);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_STATUS_CMD, {2'(m), 6'h0f});
      check({6'h00, ctrl_o.start_req, ctrl_o.stop_req}, 8'h00);
      rd(OFS_STATUS_CMD, {2'(m), 6'h20});
    end
    wr(OFS_STATUS_CMD, PAT_STOP);
    check({7'h00, ctrl_o.stop_req}, 8'h01);
    peer.hold(bus_event_t'{stop_det: 1'b1, default: '0}, 1);
    rd(OFS_TIMEOUT_CTRL, 8'h00);
    $display("Test start, mode and stop done");
    wr(OFS_CONTROL_3, 8'h01);
    peer.hold(bus_event_t'{stop_det: 1'b1, default: '0}, 1);
    #1;
    check({7'h00, ctrl_o.stop_irq}, 8'h01);
    rd(OFS_TIMEOUT_CTRL, 8'h80);
    wr(OFS_TIMEOUT_CTRL, 8'h80);
    rd(OFS_TIMEOUT_CTRL, 8'h80);
    wr(OFS_TIMEOUT_CTRL, 8'h00);
    rd(OFS_TIMEOUT_CTRL, 8'h00);
    $display("Test stop request done");
    // Short period chosen before detection is switched on; divide by 2.
    wr(OFS_TIMEOUT_CTRL, 8'h04);
    wr(OFS_TIMEOUT_CTRL, 8'h05);
    peer.hold(bus_event_t'{start_det: 1'b1, default: '0}, 1);
    peer.pull(1'b1, 4);
    n = 0;
    while (ctrl_o.timeout_irq !== 1'b1 && n < 33000) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    if (n >= 33000) begin
      n_errors++;
      complete_run();
    end
    check({7'h00, (n >= 32768) && (n <= 32772)}, 8'h01);
    rd(OFS_TIMEOUT_CTRL, 8'h07);
    wr(OFS_CONTROL_1, 8'h00);
    rd(OFS_TIMEOUT_CTRL, 8'h05);
    rd(OFS_STATUS_CMD, 8'h00);
    $display("Test timeout done");
    wr(OFS_TIMEOUT_CTRL, 8'h00);
    wr(OFS_CONTROL_1, 8'h01);
    a0 = a0 | 7'h01;
    wr(OFS_OWN_ADDR_0, {a0, 1'b0});
    wr(OFS_OWN_ADDR_1, {a0 ^ 7'h40, 1'b0});
    peer.hold(bus_event_t'{addr_rcvd: 1'b1, addr_val: a0 ^ 7'h40, default: '0}, 1);
    rd(OFS_STATUS_CMD, 8'h00);
    wr(OFS_TIMEOUT_CTRL, 8'h40);
    peer.hold(bus_event_t'{addr_rcvd: 1'b1, addr_val: a0 ^ 7'h40, default: '0}, 1);
    rd(OFS_STATUS_CMD, 8'h04);
    check({7'h00, ctrl_o.addr_match}, 8'h01);
    wr(OFS_DATA_SHIFT, {a0, 1'b1});
    check(ctrl_o.tx_data, {a0, 1'b1});
    rd(OFS_STATUS_CMD, 8'h00);
    peer.hold(bus_event_t'{addr_rcvd: 1'b1, default: '0}, 1);
    rd(OFS_STATUS_CMD, 8'h06);
    peer.hold(bus_event_t'{start_det: 1'b1, default: '0}, 1);
    rd(OFS_STATUS_CMD, 8'h24);
    peer.hold(bus_event_t'{bit_rcvd: 1'b1, bit_val: 1'b1, default: '0}, 1);
    rd(OFS_STATUS_CMD, 8'h25);
    wr(OFS_DATA_SHIFT, 8'($urandom));
    rd(OFS_STATUS_CMD, 8'h20);
    $display("Test address match done");
    // Master receive, then another master drives the data line low mid-address.
    wr(OFS_STATUS_CMD, 8'h8f);
    fork
      peer.pull(1'b0, 6);
      peer.hold(bus_event_t'{addr_phase: 1'b1, sda_out_high: 1'b1, default: '0}, 8);
    join
    rd(OFS_STATUS_CMD, 8'ha8);
    wr(OFS_DATA_SHIFT, 8'($urandom));
    rd(OFS_STATUS_CMD, 8'ha0);
    peer.hold(bus_event_t'{overlap_protect: 1'b1, default: '0}, 1);
    rd(OFS_STATUS_CMD, 8'h28);
    $display("Test arbitration done");
    repeat (2) @(posedge clk_sys_i);
    complete_run();
  end
endmodule // tb_i2c_clock_timeout_status
